// ===== pkg/flash_host_params.svh
// Constants for the flash sector-protection command host
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

// ****************************************************************
// Unlock and command codes
// ****************************************************************
`define UNLOCK_ADDR_A      12'h0AAA
`define UNLOCK_ADDR_B      12'h0555
`define UNLOCK_DATA_A      8'hAA
`define UNLOCK_DATA_B      8'h55
`define CMD_RESET          8'hF0
`define CMD_SECURE_ENTRY   8'h88
`define CMD_AUTOSEL        8'h90
`define CMD_EXIT_DATA      8'h00
`define CMD_LOCK_SETUP     8'h60
`define CMD_LOCK_PROG      8'h68
`define CMD_LOCK_CONFIRM   8'h48
`define CMD_LOCK_ERASE     8'h40
`define CMD_PW_PROGRAM     8'h38
`define CMD_PW_VERIFY      8'hC8
`define CMD_PW_UNLOCK      8'h28
`define CMD_LOCK_STATUS    8'h58
`define CMD_LOCK_BIT_SET   8'h78
`define CMD_VOL_LOCK       8'h48
`define CMD_SUSPEND        8'hB0
`define CMD_RESUME         8'h30
`define CMD_ACCEL_PROG     8'hA0
`define CMD_BYPASS_ENTRY   8'h20
`define CMD_BYPASS_RST0    8'h90
`define CMD_BYPASS_RST1    8'h00

// ****************************************************************
// Lock addresses (low bits) and answer values
// ****************************************************************
`define SECURE_LOCK_ADDR   7'h1A
`define PERSIST_PROG_ADDR  7'h3A
`define PERSIST_ERASE_ADDR 7'h7A
`define PW_MODE_LOCK_ADDR  6'h0A
`define PS_MODE_LOCK_ADDR  6'h12
`define FACTORY_LOCKED     8'h80
`define PW_MASKED          8'hFF

// ****************************************************************
// Timing: printed times and derived 125 MHz cycle counts
// ****************************************************************
`define CLK_PERIOD_PS      8000
`define LOCK_WAIT_NS       100000
`define ERASE_WAIT_NS      1200000
`define PW_GAP_NS          2000
`define CYC(ns)            (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WE_LOW_CYC         4
`define WE_HIGH_CYC        4

`endif

// ===== pkg/flash_host_pkg.sv
// Types shared by the flash command host
package flash_host_pkg;
  typedef enum logic [3:0] {
    OP_RESET,
    OP_SECURE_LOCK,
    OP_PERSIST_PROG,
    OP_PERSIST_ERASE,
    OP_PW_PROGRAM,
    OP_PW_VERIFY,
    OP_PW_UNLOCK,
    OP_LOCK_STATUS,
    OP_VOL_LOCK,
    OP_PW_MODE_PROG,
    OP_PS_MODE_PROG,
    OP_SUSPEND,
    OP_RESUME,
    OP_ACCEL_PROG,
    OP_BYPASS_ENTRY,
    OP_BYPASS_RESET
  } op_e;

  typedef enum logic [1:0] {
    RES_OK,
    RES_RETRY,
    RES_REFUSED
  } result_e;
endpackage

// ===== design/bus_cycle.sv
// One asynchronous flash bus cycle: write or read, with strobe timing
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_params.svh"
module bus_cycle #(
  parameter int AW = 22,
  parameter int DW = 16
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          go,
  input  wire logic          rd,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output var  logic          done,
  output var  logic [DW-1:0] rdata,
  output var  logic [AW-1:0] flash_addr,
  output var  logic [DW-1:0] flash_dq_out,
  output var  logic          flash_dq_oe_n,
  input  wire logic [DW-1:0] flash_dq_in,
  output var  logic          flash_ce_n,
  output var  logic          flash_we_n,
  output var  logic          flash_oe_n
);
  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_LOW, CY_HIGH} cy_e;
  cy_e             st_r, st_nxt;
  logic [3:0]      cnt_r, cnt_nxt;
  logic            rd_r, rd_nxt;
  logic [AW-1:0]   a_r, a_nxt;
  logic [DW-1:0]   d_r, d_nxt, q_r, q_nxt;

  // ****************************************************************
  // Address set up before the strobe falls, data held past its rise
  // ****************************************************************
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    rd_nxt  = rd_r;
    a_nxt   = a_r;
    d_nxt   = d_r;
    q_nxt   = q_r;
    done    = 1'b0;
    unique case (st_r)
      CY_IDLE: if (go) begin
        st_nxt  = CY_SETUP;
        cnt_nxt = 4'(`WE_LOW_CYC);
        rd_nxt  = rd;
        a_nxt   = addr;
        d_nxt   = wdata;
      end
      CY_SETUP: st_nxt = CY_LOW;
      CY_LOW: if (cnt_r == 4'h1) begin
        st_nxt  = CY_HIGH;
        cnt_nxt = 4'(`WE_HIGH_CYC);
        q_nxt   = flash_dq_in;
      end else begin
        cnt_nxt = cnt_r - 4'h1;
      end
      CY_HIGH: if (cnt_r == 4'h1) begin
        st_nxt = CY_IDLE;
        done   = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 4'h1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r  <= CY_IDLE;
      cnt_r <= 4'h0;
      rd_r  <= 1'b0;
      a_r   <= '0;
      d_r   <= '0;
      q_r   <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      rd_r  <= rd_nxt;
      a_r   <= a_nxt;
      d_r   <= d_nxt;
      q_r   <= q_nxt;
    end
  end

  // Select leads the strobe by a cycle, so the strobe edges do the latching
  assign flash_addr    = a_r;
  assign flash_dq_out  = d_r;
  assign rdata         = q_r;
  assign flash_ce_n    = !(st_r inside {CY_SETUP, CY_LOW});
  assign flash_we_n    = !(st_r == CY_LOW && !rd_r);
  assign flash_oe_n    = !(st_r == CY_LOW && rd_r);
  assign flash_dq_oe_n = !(st_r != CY_IDLE && !rd_r);
endmodule
`default_nettype wire

// ===== design/flash_prot_host.sv
// Host sequencer for flash protection and array command sequences
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_params.svh"
module flash_prot_host
  import flash_host_pkg::*;
#(
  parameter int AW          = 22,
  parameter int DW          = 16,
  parameter int LOCK_CYC    = `CYC(`LOCK_WAIT_NS),
  parameter int ERASE_CYC   = `CYC(`ERASE_WAIT_NS),
  parameter int PW_GAP_CYC  = `CYC(`PW_GAP_NS)
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    cmd_valid,
  output var  logic                    cmd_ready,
  input  wire flash_host_pkg::op_e     cmd_op,
  input  wire logic [AW-1:0]           cmd_addr,
  input  wire logic [DW-1:0]           cmd_data,
  input  wire logic [4*DW-1:0]         cmd_password,
  input  wire logic                    erase_active,
  output var  logic                    rsp_valid,
  output var  flash_host_pkg::result_e rsp_result,
  output var  logic [DW-1:0]           rsp_data,
  output var  logic [AW-1:0]           flash_addr,
  output var  logic [DW-1:0]           flash_dq_out,
  output var  logic                    flash_dq_oe_n,
  input  wire logic [DW-1:0]           flash_dq_in,
  output var  logic                    flash_ce_n,
  output var  logic                    flash_we_n,
  output var  logic                    flash_oe_n,
  output var  logic                    acceleration_pin
);
  import flash_host_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_ISSUE, S_WAIT_CYC, S_PAUSE, S_DONE
  } st_e;

  st_e            st_r, st_nxt;
  op_e            op_r, op_nxt;
  logic [2:0]     step_r, step_nxt;
  logic [20:0]    tmr_r, tmr_nxt;
  logic [AW-1:0]  a_r, a_nxt;
  logic [DW-1:0]  d_r, d_nxt;
  logic [4*DW-1:0] pw_r, pw_nxt;
  logic           susp_r, susp_nxt;
  logic           byp_r, byp_nxt;
  logic           rv_r, rv_nxt;
  result_e        res_r, res_nxt;
  logic [DW-1:0]  rd_r, rd_nxt;

  logic           go, cyc_rd, cyc_done;
  logic [AW-1:0]  cyc_a;
  logic [DW-1:0]  cyc_d, cyc_q;
  logic           last;
  logic [20:0]    pause;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Command cycles carry only A11:A0 and DQ7:DQ0; bank bits optional
  function automatic logic [AW-1:0] cmd_a(input logic [11:0] lo,
                                          input logic [AW-1:0] bank,
                                          input logic use_bank);
    logic [AW-1:0] r;
    r = use_bank ? {bank[AW-1:12], lo} : {{(AW-12){1'b0}}, lo};
    return r;
  endfunction

  function automatic logic [DW-1:0] cmd_d(input logic [7:0] v);
    return {{(DW-8){1'b0}}, v};
  endfunction

  function automatic logic [AW-1:0] lock_a(input logic [AW-1:0] sect,
                                           input logic [6:0] lo);
    return {sect[AW-1:7], lo};
  endfunction

  // ****************************************************************
  // Build each bus cycle of the running sequence
  // ****************************************************************
  always_comb begin
    cyc_rd = 1'b0;
    cyc_a  = '0;
    cyc_d  = '0;
    last   = 1'b0;
    pause  = '0;
    unique case (step_r)
      3'd0: begin
        cyc_a = cmd_a(`UNLOCK_ADDR_A, a_r, 1'b0);
        cyc_d = cmd_d(`UNLOCK_DATA_A);
      end
      3'd1: begin
        cyc_a = cmd_a(`UNLOCK_ADDR_B, a_r, 1'b0);
        cyc_d = cmd_d(`UNLOCK_DATA_B);
      end
      default: begin
        cyc_a = cmd_a(`UNLOCK_ADDR_A, a_r, 1'b1);
      end
    endcase
    unique case (op_r)
      OP_RESET: begin
        cyc_d = cmd_d(`CMD_RESET);
        last  = 1'b1;
      end
      OP_SUSPEND, OP_RESUME: begin
        cyc_a = cmd_a(12'h000, a_r, 1'b1);
        cyc_d = cmd_d(op_r == OP_SUSPEND ? `CMD_SUSPEND : `CMD_RESUME);
        last  = 1'b1;
      end
      OP_ACCEL_PROG: begin
        if (step_r == 3'd0) begin
          cyc_d = cmd_d(`CMD_ACCEL_PROG);
        end else begin
          cyc_a = a_r;
          cyc_d = d_r;
          last  = 1'b1;
        end
      end
      OP_BYPASS_RESET: begin
        cyc_d = cmd_d(step_r == 3'd0 ? `CMD_BYPASS_RST0
                                     : `CMD_BYPASS_RST1);
        last  = (step_r == 3'd1);
      end
      OP_BYPASS_ENTRY: begin
        if (step_r == 3'd2) begin
          cyc_d = cmd_d(`CMD_BYPASS_ENTRY);
          last  = 1'b1;
        end
      end
      OP_VOL_LOCK, OP_LOCK_STATUS, OP_PW_VERIFY: begin
        if (step_r == 3'd2) begin
          cyc_d = cmd_d(op_r == OP_VOL_LOCK    ? `CMD_VOL_LOCK :
                        op_r == OP_LOCK_STATUS ? `CMD_LOCK_STATUS
                                               : `CMD_PW_VERIFY);
        end else if (step_r == 3'd3) begin
          cyc_a  = a_r;
          cyc_d  = {{(DW-1){1'b0}}, d_r[0]};
          cyc_rd = (op_r != OP_VOL_LOCK);
          last   = 1'b1;
        end
      end
      OP_PW_PROGRAM, OP_PW_UNLOCK: begin
        if (step_r == 3'd2) begin
          cyc_d = cmd_d(op_r == OP_PW_PROGRAM ? `CMD_PW_PROGRAM
                                              : `CMD_PW_UNLOCK);
        end else if (step_r >= 3'd3) begin
          cyc_a = {{(AW-2){1'b0}}, (op_r == OP_PW_PROGRAM) ? a_r[1:0]
                                   : 2'(step_r - 3'd3)};
          cyc_d = (op_r == OP_PW_PROGRAM) ? d_r : pw_r[DW-1:0];
          last  = (op_r == OP_PW_PROGRAM) || (step_r == 3'd6);
          pause = 21'(PW_GAP_CYC);
        end
      end
      default: begin
        // Six-cycle lock program or erase sequences
        if (step_r == 3'd2) begin
          cyc_d = cmd_d(`CMD_LOCK_SETUP);
        end else if (step_r >= 3'd3) begin
          unique case (op_r)
            OP_SECURE_LOCK:   cyc_a = lock_a(a_r, `SECURE_LOCK_ADDR);
            OP_PERSIST_PROG:  cyc_a = lock_a(a_r, `PERSIST_PROG_ADDR);
            OP_PERSIST_ERASE: cyc_a = lock_a(a_r, (step_r == 3'd5)
                                  ? `PERSIST_PROG_ADDR
                                  : `PERSIST_ERASE_ADDR);
            OP_PW_MODE_PROG:  cyc_a = lock_a(a_r,
                                  {1'b0, `PW_MODE_LOCK_ADDR});
            default:          cyc_a = lock_a(a_r,
                                  {1'b0, `PS_MODE_LOCK_ADDR});
          endcase
          if (step_r == 3'd3) begin
            cyc_d = cmd_d(op_r == OP_PERSIST_ERASE ? `CMD_LOCK_SETUP
                                                   : `CMD_LOCK_PROG);
            pause = (op_r == OP_PERSIST_ERASE) ? 21'(ERASE_CYC)
                                               : 21'(LOCK_CYC);
          end else if (step_r == 3'd4) begin
            cyc_d = cmd_d(op_r == OP_PERSIST_ERASE ? `CMD_LOCK_ERASE
                                                   : `CMD_LOCK_CONFIRM);
          end else begin
            cyc_rd = 1'b1;
            last   = 1'b1;
          end
        end
      end
    endcase
  end

  // ****************************************************************
  // Sequence control
  // ****************************************************************
  always_comb begin
    st_nxt   = st_r;
    op_nxt   = op_r;
    step_nxt = step_r;
    tmr_nxt  = tmr_r;
    a_nxt    = a_r;
    d_nxt    = d_r;
    pw_nxt   = pw_r;
    susp_nxt = susp_r;
    byp_nxt  = byp_r;
    rv_nxt   = 1'b0;
    res_nxt  = res_r;
    rd_nxt   = rd_r;
    go       = 1'b0;
    unique case (st_r)
      S_IDLE: if (cmd_valid) begin
        op_nxt  = cmd_op;
        a_nxt   = cmd_addr;
        d_nxt   = cmd_data;
        pw_nxt  = cmd_password;
        rd_nxt  = '0;
        res_nxt = RES_OK;
        step_nxt = (cmd_op == OP_RESET || cmd_op == OP_SUSPEND ||
                    cmd_op == OP_RESUME || cmd_op == OP_ACCEL_PROG ||
                    cmd_op == OP_BYPASS_RESET) ? 3'd7 : 3'd0;
        st_nxt  = S_ISSUE;
        // Refuse orders the device would ignore
        if ((cmd_op == OP_SUSPEND && (!erase_active || susp_r)) ||
            (cmd_op == OP_RESUME && !susp_r) ||
            (cmd_op == OP_ACCEL_PROG && (erase_active || susp_r)) ||
            (cmd_op == OP_BYPASS_RESET && !byp_r)) begin
          res_nxt = RES_REFUSED;
          st_nxt  = S_DONE;
        end
      end
      S_ISSUE: begin
        // Single- and two-cycle orders start at step 7 marker
        if (step_r == 3'd7) begin
          step_nxt = 3'd0;
        end else begin
          go     = 1'b1;
          st_nxt = S_WAIT_CYC;
        end
      end
      S_WAIT_CYC: if (cyc_done) begin
        if (cyc_rd) begin
          rd_nxt = cyc_q;
        end
        if (last) begin
          st_nxt = S_DONE;
          if (op_r == OP_SUSPEND) susp_nxt = 1'b1;
          if (op_r == OP_RESUME) susp_nxt = 1'b0;
          if (op_r == OP_BYPASS_ENTRY) byp_nxt = 1'b1;
          if (op_r == OP_BYPASS_RESET) byp_nxt = 1'b0;
          if (op_r == OP_PERSIST_ERASE && cyc_q[0]) begin
            res_nxt = RES_RETRY;
          end else if ((op_r == OP_SECURE_LOCK || op_r == OP_PERSIST_PROG
                        || op_r == OP_PW_MODE_PROG || op_r == OP_PS_MODE_PROG)
                       && !cyc_q[0]) begin
            res_nxt = RES_RETRY;
          end
        end else begin
          step_nxt = step_r + 3'd1;
          if (op_r == OP_PW_UNLOCK && step_r >= 3'd3) begin
            pw_nxt = pw_r >> DW;
          end
          tmr_nxt = pause;
          st_nxt  = (pause != '0) ? S_PAUSE : S_ISSUE;
        end
      end
      S_PAUSE: if (tmr_r <= 21'd1) begin
        st_nxt = S_ISSUE;
      end else begin
        tmr_nxt = tmr_r - 21'd1;
      end
      S_DONE: begin
        rv_nxt = 1'b1;
        st_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= S_IDLE;
      op_r   <= OP_RESET;
      step_r <= 3'd0;
      tmr_r  <= '0;
      a_r    <= '0;
      d_r    <= '0;
      pw_r   <= '0;
      susp_r <= 1'b0;
      byp_r  <= 1'b0;
      rv_r   <= 1'b0;
      res_r  <= RES_OK;
      rd_r   <= '0;
    end else begin
      st_r   <= st_nxt;
      op_r   <= op_nxt;
      step_r <= step_nxt;
      tmr_r  <= tmr_nxt;
      a_r    <= a_nxt;
      d_r    <= d_nxt;
      pw_r   <= pw_nxt;
      susp_r <= susp_nxt;
      byp_r  <= byp_nxt;
      rv_r   <= rv_nxt;
      res_r  <= res_nxt;
      rd_r   <= rd_nxt;
    end
  end

  assign cmd_ready        = (st_r == S_IDLE);
  assign rsp_valid        = rv_r;
  assign rsp_result       = res_r;
  assign rsp_data         = rd_r;
  // Raised only for the accelerated program so it cannot leak elsewhere
  assign acceleration_pin = (op_r == OP_ACCEL_PROG) && (st_r != S_IDLE)
                            && (res_r != RES_REFUSED);

  bus_cycle #(.AW(AW), .DW(DW)) u_cycle (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .go            (go),
    .rd            (cyc_rd),
    .addr          (cyc_a),
    .wdata         (cyc_d),
    .done          (cyc_done),
    .rdata         (cyc_q),
    .flash_addr    (flash_addr),
    .flash_dq_out  (flash_dq_out),
    .flash_dq_oe_n (flash_dq_oe_n),
    .flash_dq_in   (flash_dq_in),
    .flash_ce_n    (flash_ce_n),
    .flash_we_n    (flash_we_n),
    .flash_oe_n    (flash_oe_n)
  );
endmodule
`default_nettype wire

// ===== verif/flash_prot_host_monitor.sv
// Port-level checker for the flash protection command host
`timescale 1ns/1ps
`default_nettype none
module flash_prot_host_monitor
  import flash_host_pkg::*;
#(
  parameter int AW = 22,
  parameter int DW = 16
) (
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  input wire logic                    cmd_valid,
  input wire logic                    cmd_ready,
  input wire flash_host_pkg::op_e     cmd_op,
  input wire logic                    erase_active,
  input wire logic                    rsp_valid,
  input wire flash_host_pkg::result_e rsp_result,
  input wire logic [AW-1:0]           flash_addr,
  input wire logic [DW-1:0]           flash_dq_out,
  input wire logic                    flash_dq_oe_n,
  input wire logic                    flash_ce_n,
  input wire logic                    flash_we_n,
  input wire logic                    flash_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ************************************
  // Sequences
  // ************************************
  sequence s_taken(op_e o);
    cmd_valid && cmd_ready && cmd_op == o;
  endsequence
  sequence s_refused;
    rsp_valid && rsp_result == RES_REFUSED;
  endsequence
  sequence s_we_pulse;
    (!flash_we_n)[*4] ##1 flash_we_n;
  endsequence

  // ************************************
  // Assertions
  // ************************************
  a_idle_quiet: assert property (
    cmd_ready |-> flash_ce_n && flash_we_n && flash_oe_n)
    else $error("bus strobe active while idle");
  a_we_width: assert property ($fell(flash_we_n) |-> s_we_pulse)
    else $error("write strobe low phase not four cycles");
  a_addr_held: assert property (
    $fell(flash_we_n) |-> $stable(flash_addr)
      ##1 ($stable(flash_addr) && $stable(flash_dq_out))[*4])
    else $error("address or data moved during write");
  a_ce_with_we: assert property (
    !flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe without select");
  a_dq_driven: assert property (!flash_we_n |-> !flash_dq_oe_n)
    else $error("data not driven during write");
  a_dq_released: assert property (!flash_oe_n |-> flash_dq_oe_n)
    else $error("data driven during read");
  a_suspend_refused: assert property (
    s_taken(OP_SUSPEND) ##0 !erase_active |-> ##2 s_refused)
    else $error("suspend without erase not refused");
  a_accel_refused: assert property (
    s_taken(OP_ACCEL_PROG) ##0 erase_active |->
      (flash_ce_n)[*3] and ##2 s_refused)
    else $error("accelerated program during erase not refused");
endmodule

bind flash_prot_host flash_prot_host_monitor #(.AW(AW), .DW(DW))
  i_flash_prot_host_monitor (
  .sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_op(cmd_op), .erase_active(erase_active),
  .rsp_valid(rsp_valid), .rsp_result(rsp_result),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
  .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n),
  .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));
`default_nettype wire

// ===== verif/flash_dev_model.sv
// Behavioural flash device answering the protection command sequences
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
  input  wire logic [21:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  input  wire logic        fail,
  input  wire logic        lock_state,
  output wire logic [15:0] flash_dq_in,
  output var  logic [21:0] last_wa,
  output var  logic [15:0] last_wd,
  output var  logic [7:0]  cmd_byte,
  output var  logic        vol_bit,
  output var  logic        dirty,
  output var  int          gap_ns
);
  logic [21:0] la;
  logic [15:0] pw [4];
  logic [15:0] rv;
  logic [15:0] rv_q;
  logic [7:0]  d;
  logic        ers;
  logic        pw_lock;
  int          ph;
  realtime     t_prev;

  // ************************************
  // Write decode
  // ************************************
  initial begin
    ph = 0; ers = 0; pw_lock = 0; vol_bit = 0; dirty = 0;
    rv_q = '0; t_prev = 0; cmd_byte = '0; gap_ns = 0;
  end
  always @(negedge flash_we_n) if (!flash_ce_n) la = flash_addr;
  always @(posedge flash_we_n) begin
    gap_ns = int'($realtime - t_prev);
    t_prev = $realtime;
    last_wa = la;
    last_wd = flash_dq_out;
    d = flash_dq_out[7:0];
    if (d == 8'hF0) begin
      ph = 0;
    end else if (ph != 2 && d == 8'hAA && la[11:0] == 12'hAAA) begin
      ph = 1;
      dirty = dirty | (la[21:12] != 0) | (flash_dq_out[15:8] != 0);
    end else if (ph == 1 && d == 8'h55 && la[11:0] == 12'h555) begin
      ph = 2;
      dirty = dirty | (la[21:12] != 0) | (flash_dq_out[15:8] != 0);
    end else if (ph == 2) begin
      cmd_byte = d;
      ers = 0;
      ph = 3;
    end else if (ph >= 3) begin
      ph = ph + 1;
      if (cmd_byte == 8'h38) pw[la[1:0]] = flash_dq_out;
      if (cmd_byte == 8'h48) vol_bit = flash_dq_out[0];
      if (cmd_byte == 8'h60 && d == 8'h40) ers = 1;
      if (cmd_byte == 8'h60 && la[5:0] == 6'h0A && d == 8'h48) begin
        pw_lock = 1;
      end
    end
  end

  // ************************************
  // Read answers
  // ************************************
  always @* begin
    if (cmd_byte == 8'h58) rv = {14'h0, lock_state, 1'b0};
    else if (cmd_byte == 8'hC8) rv = pw_lock ? 16'hFFFF : pw[flash_addr[1:0]];
    else rv = {15'h0, ers ? fail : !fail};
  end
  always @(posedge flash_oe_n) rv_q = rv;
  // A released bus shows the inverse so a late sample cannot pass
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rv : ~rv_q;
endmodule
`default_nettype wire

// ===== verif/flash_prot_host_tb.sv
// Self-checking testbench for the flash protection command host
`timescale 1ns/1ps
`default_nettype none
module flash_prot_host_tb;
  import flash_host_pkg::*;
  localparam int GAP = 5;
  localparam int MIN_NS = (GAP + 8) * 8;
  logic        sys_clk, rst_n, cmd_valid, erase_active, fail, lock_state;
  logic        cmd_ready, rsp_valid, dq_oe_n, ce_n, we_n, oe_n, accel;
  logic        vol_bit, dirty, acc_seen;
  op_e         cmd_op;
  result_e     rsp_result, got_res;
  logic [21:0] cmd_addr, f_addr, last_wa;
  logic [15:0] cmd_data, rsp_data, dq_o, dq_i, last_wd, got_data;
  logic [63:0] password_check_value;
  logic [7:0]  cmd_byte;
  int          gap_ns, bad_count, tests_run, cyc;
  op_e         t_op [13] = '{OP_SUSPEND, OP_RESUME, OP_BYPASS_RESET,
    OP_SUSPEND, OP_ACCEL_PROG, OP_SUSPEND, OP_RESUME, OP_ACCEL_PROG,
    OP_BYPASS_ENTRY, OP_BYPASS_RESET, OP_SUSPEND, OP_RESET, OP_RESUME};
  logic        t_ea [13] = '{0, 0, 0, 1, 1, 1, 1, 0, 0, 0, 1, 0, 0};
  result_e     t_res [13] = '{RES_REFUSED, RES_REFUSED, RES_REFUSED,
    RES_OK, RES_REFUSED, RES_REFUSED, RES_OK, RES_OK, RES_OK, RES_OK,
    RES_OK, RES_OK, RES_OK};

  flash_prot_host #(.LOCK_CYC(GAP), .ERASE_CYC(GAP), .PW_GAP_CYC(GAP))
    i_flash_prot_host (.sys_clk(sys_clk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_password(password_check_value),
    .erase_active(erase_active), .rsp_valid(rsp_valid),
    .rsp_result(rsp_result), .rsp_data(rsp_data), .flash_addr(f_addr),
    .flash_dq_out(dq_o), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_i),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .acceleration_pin(accel));
  flash_dev_model i_flash_dev_model (.flash_addr(f_addr),
    .flash_dq_out(dq_o), .flash_ce_n(ce_n), .flash_we_n(we_n),
    .flash_oe_n(oe_n), .fail(fail), .lock_state(lock_state),
    .flash_dq_in(dq_i), .last_wa(last_wa), .last_wd(last_wd),
    .cmd_byte(cmd_byte), .vol_bit(vol_bit), .dirty(dirty),
    .gap_ns(gap_ns));

  // ************************************
  // Clock, timeout and reporting
  // ************************************
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  always @(posedge sys_clk) if (!we_n && accel) acc_seen <= 1;
  task automatic close_out();
    $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_res(result_e g, result_e e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_val(logic [15:0] g, logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One order: held until taken, then wait for its answer
  task automatic run(op_e op, logic [21:0] a, logic [15:0] d, logic ea);
    int n;
    n = 0;
    @(posedge sys_clk);
    cmd_valid <= 1; cmd_op <= op; cmd_addr <= a; cmd_data <= d;
    erase_active <= ea;
    @(negedge sys_clk);
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    cmd_valid <= 0;
    n = 0;
    @(negedge sys_clk);
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 3000) chk_val(16'h0, 16'h1);
    got_res = rsp_result;
    got_data = rsp_data;
  endtask

  // ************************************
  // Main sequence
  // ************************************
  initial begin
    rst_n = 0; cmd_valid = 0; cmd_op = OP_RESET; cmd_addr = '0;
    cmd_data = '0; erase_active = 0; fail = 0; lock_state = 0;
    acc_seen = 0;
    password_check_value = 64'h1357_2468_0123_4567; bad_count = 0; tests_run = 0; cyc = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1;
    run(OP_SECURE_LOCK, 22'h3F_F000, 16'h0000, 0);
    chk_res(got_res, RES_OK);
    chk_val({8'h00, cmd_byte}, 16'h0060);
    chk_val({9'h000, last_wa[6:0]}, 16'h001A);
    chk_val(last_wd, 16'h0048);
    for (int f = 0; f < 2; f++) begin
      @(posedge sys_clk) fail <= f[0];
      run(OP_PERSIST_PROG, 22'h12_3000, 16'h0000, 0);
      chk_res(got_res, f ? RES_RETRY : RES_OK);
      chk_val({9'h000, last_wa[6:0]}, 16'h003A);
      chk_val(16'(gap_ns >= MIN_NS), 16'h0001);
      run(OP_PERSIST_ERASE, 22'h12_3000, 16'h0000, 0);
      chk_res(got_res, f ? RES_RETRY : RES_OK);
      chk_val({9'h000, last_wa[6:0]}, 16'h007A);
      chk_val(last_wd, 16'h0040);
      chk_val(16'(gap_ns >= MIN_NS), 16'h0001);
    end
    @(posedge sys_clk) fail <= 0;
    run(OP_PW_PROGRAM, 22'h00_0002, 16'h5A3C, 0);
    chk_val({14'h0, last_wa[1:0]}, 16'h0002);
    chk_val(last_wd, 16'h5A3C);
    run(OP_PW_UNLOCK, 22'h00_0000, 16'h0000, 0);
    chk_val({14'h0, last_wa[1:0]}, 16'h0003);
    chk_val(last_wd, password_check_value[63:48]);
    chk_val(16'(gap_ns >= MIN_NS), 16'h0001);
    run(OP_PS_MODE_PROG, 22'h00_0000, 16'h0000, 0);
    chk_val({10'h000, last_wa[5:0]}, 16'h0012);
    run(OP_PW_MODE_PROG, 22'h00_0000, 16'h0000, 0);
    chk_val({10'h000, last_wa[5:0]}, 16'h000A);
    run(OP_PW_VERIFY, 22'h00_0000, 16'h0000, 0);
    chk_val({8'h00, got_data[7:0]}, 16'h00FF);
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk) lock_state <= s[0];
      run(OP_LOCK_STATUS, 22'h10_0000, 16'h0000, 0);
      chk_val({15'h0, got_data[1]}, 16'(s));
    end
    for (int i = 0; i < 13; i++) begin
      run(t_op[i], 22'h20_0000, 16'h0000, t_ea[i]);
      chk_res(got_res, t_res[i]);
    end
    for (int v = 1; v >= 0; v--) begin
      run(OP_VOL_LOCK, 22'h08_0000, 16'(v), 0);
      chk_val({15'h0, vol_bit}, 16'(v));
    end
    chk_val({15'h0, dirty}, 16'h0000);
    chk_val({15'h0, acc_seen}, 16'h0001);
    close_out();
  end
endmodule
`default_nettype wire
